// File: design/dcbmf_top.sv
`timescale 1ns/1ps
module dcbmf_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        write_clk,
	input  wire logic        read_clk,
	input  wire logic        serial_clk,
	input  wire logic        write_en_n,
	input  wire logic        read_en_n,
	input  wire logic        load_strobe_n,
	input  wire logic        serial_load_enable_n,
	input  wire logic        mode_or_serial_pin,
	input  wire logic        full_reset_n,
	input  wire logic        pointer_reset_n,
	input  wire logic        replay_request_n,
	input  wire logic        replay_latency_select,
	input  wire logic        level_flag_timing_select,
	input  wire logic        width_match_enable,
	input  wire logic        write_width_select,
	input  wire logic        read_width_select,
	input  wire logic        word_order_select,
	input  wire logic        parity_layout_select,
	input  wire logic        default_choice_0,
	input  wire logic        default_choice_1,
	input  wire logic        read_port_select_n,
	input  wire logic        output_drive_en_n,
	input  wire logic [71:0] write_data_bus,
	output logic      [71:0] read_data_bus,
	output logic             read_data_oe_n,
	output logic             empty_or_output_ready,
	output logic             full_or_input_ready,
	output logic             half_full_flag,
	output logic             almost_empty_flag,
	output logic             almost_full_flag,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	// ======================================
	// pin synchronisers and edge enables
	dcbmf_pkg::dcbmf_pins_s pin_raw;
	dcbmf_pkg::dcbmf_pins_s pin_m;
	dcbmf_pkg::dcbmf_pins_s pin_s;
	logic                   wclk_d;
	logic                   rclk_d;
	logic                   sclk_d;
	dcbmf_pkg::dcbmf_cfg_s  cfg;
	logic [8:0]             ae_off;
	logic [8:0]             af_off;
	logic                   load_sel;
	logic                   rd_sel;
	logic [71:0]            mem [dcbmf_pkg::DEPTH];
	logic [9:0]             wptr;
	logic [9:0]             rptr;
	logic [71:0]            wr_acc;
	logic [1:0]             wr_k;
	logic [71:0]            rd_hold;
	logic [1:0]             rd_k;
	logic                   rd_held;
	logic                   out_valid;
	logic [1:0]             ft_cnt;
	logic                   rps;
	logic                   rd_upd;
	logic                   wr_upd;
	logic                   sw_prst;
	logic [7:0]             aw_addr;
	logic [31:0]            w_data;
	logic [3:0]             w_strb;
	logic                   aw_got;
	logic                   w_got;
	logic [31:0]            rd_mux;
	logic                   rd_hit;

	assign pin_raw = {write_clk, read_clk, serial_clk, write_en_n, read_en_n, load_strobe_n,
		serial_load_enable_n, mode_or_serial_pin, full_reset_n, pointer_reset_n,
		replay_request_n, replay_latency_select, level_flag_timing_select, width_match_enable,
		write_width_select, read_width_select, word_order_select, parity_layout_select,
		default_choice_0, default_choice_1, read_port_select_n, output_drive_en_n,
		write_data_bus};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_m  <= '0;
			pin_s  <= '0;
			wclk_d <= 1'b0;
			rclk_d <= 1'b0;
			sclk_d <= 1'b0;
		end else begin
			pin_m  <= pin_raw;
			pin_s  <= pin_m;
			wclk_d <= pin_s.write_clk;
			rclk_d <= pin_s.read_clk;
			sclk_d <= pin_s.serial_clk;
		end
	end

	// data and clocks share the same two-stage delay, so they stay aligned
	wire wr_edge   = pin_s.write_clk & ~wclk_d;
	wire rd_edge   = pin_s.read_clk & ~rclk_d;
	wire sclk_edge = pin_s.serial_clk & ~sclk_d;
	wire full_rst  = ~pin_s.full_reset_n;
	wire ptr_rst   = full_rst | ~pin_s.pointer_reset_n | sw_prst;

	// ======================================
	// reset-time configuration
	// modes latched while full reset held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg <= '0;
		end else if (full_rst) begin
			cfg.fall_through_mode <= pin_s.mode_or_serial_pin;
			cfg.replay_zero   <= ~pin_s.replay_latency_select;
			cfg.flag_sync     <= pin_s.level_flag_timing_select;
			cfg.little_endian <= pin_s.word_order_select;
			cfg.interspersed  <= pin_s.parity_layout_select;
			if (!pin_s.width_match_enable) begin
				cfg.wr_shift <= dcbmf_pkg::SHIFT_X72;
				cfg.rd_shift <= dcbmf_pkg::SHIFT_X72;
			end else if (pin_s.write_width_select) begin
				cfg.wr_shift <= pin_s.read_width_select ? dcbmf_pkg::SHIFT_X18
					: dcbmf_pkg::SHIFT_X36;
				cfg.rd_shift <= dcbmf_pkg::SHIFT_X72;
			end else begin
				cfg.wr_shift <= dcbmf_pkg::SHIFT_X72;
				cfg.rd_shift <= pin_s.read_width_select ? dcbmf_pkg::SHIFT_X18
					: dcbmf_pkg::SHIFT_X36;
			end
		end
	end

	// ======================================
	// flag offsets
	wire [8:0] par_val = cfg.interspersed
		? {pin_s.write_data_bus[dcbmf_pkg::PARITY_BIT + 1],
		   pin_s.write_data_bus[dcbmf_pkg::PARITY_BIT - 1:0]}
		: pin_s.write_data_bus[dcbmf_pkg::OFF_W - 1:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ae_off   <= '0;
			af_off   <= '0;
			load_sel <= 1'b0;
		end else if (full_rst) begin
			ae_off   <= dcbmf_pkg::DEFAULT_OFF[{pin_s.load_strobe_n, pin_s.default_choice_1,
				pin_s.default_choice_0}];
			af_off   <= dcbmf_pkg::DEFAULT_OFF[{pin_s.load_strobe_n, pin_s.default_choice_1,
				pin_s.default_choice_0}];
			load_sel <= 1'b0;
		end else if (sclk_edge && !pin_s.serial_load_enable_n && !pin_s.load_strobe_n) begin
			{af_off, ae_off} <= {af_off[dcbmf_pkg::OFF_W - 2:0], ae_off,
				pin_s.mode_or_serial_pin};
		end else if (wr_edge && !pin_s.write_en_n && !pin_s.load_strobe_n) begin
			if (load_sel) begin
				af_off <= par_val;
			end else begin
				ae_off <= par_val;
			end
			load_sel <= ~load_sel;
		end
	end

	// ======================================
	// write side
	wire [1:0]  wr_last   = dcbmf_pkg::last_piece(cfg.wr_shift);
	wire [1:0]  rd_last   = dcbmf_pkg::last_piece(cfg.rd_shift);
	// both pointers live in one clock domain, so the fill count is exact
	wire [9:0]  fill      = wptr - rptr;
	wire        full_now  = fill == dcbmf_pkg::FILL_FULL;
	wire        wr_go     = wr_edge & ~pin_s.write_en_n & pin_s.load_strobe_n;
	wire [71:0] next_acc  = dcbmf_pkg::place_piece(wr_acc, pin_s.write_data_bus, wr_k,
		cfg.wr_shift, cfg.little_endian);
	wire        wr_commit = wr_go & (wr_k == wr_last) & ~full_now;

	// assemble narrow pieces, commit full long word
	always_ff @(posedge aclk) begin
		if (!aresetn || ptr_rst) begin
			wptr   <= '0;
			wr_k   <= '0;
			wr_acc <= '0;
		end else if (wr_go) begin
			if (wr_k == wr_last) begin
				wr_k   <= '0;
				wr_acc <= '0;
				if (!full_now) begin
					wptr <= wptr + dcbmf_pkg::PTR_ONE;
				end
			end else begin
				wr_k   <= wr_k + 2'h1;
				wr_acc <= next_acc;
			end
		end
	end

	// data storage is not cleared by either reset
	always_ff @(posedge aclk) begin
		if (wr_commit) begin
			mem[wptr[dcbmf_pkg::ADDR_W - 1:0]] <= next_acc;
		end
	end

	// ======================================
	// read side
	wire [71:0] mem_head  = mem[rptr[dcbmf_pkg::ADDR_W - 1:0]];
	wire        held_more = rd_held & (rd_k != rd_last);
	wire        avail     = held_more | (fill != '0);
	wire        ren_ok    = rd_edge & ~pin_s.read_en_n & ~pin_s.read_port_select_n;
	wire        ren_data  = ren_ok & pin_s.load_strobe_n;
	wire        readback  = ren_ok & ~pin_s.load_strobe_n;
	wire        replay    = rd_edge & ~pin_s.replay_request_n;
	wire        ft        = cfg.fall_through_mode;
	wire        ft_fire   = ~out_valid & avail & rd_edge & (ft_cnt == dcbmf_pkg::FT_LAST);
	// standard needs a read; fall-through refills itself
	wire        step      = ft ? ((ren_data & out_valid & avail) | ft_fire)
		: (ren_data & avail);
	wire        drain     = ft & ren_data & out_valid & ~avail;
	wire        ft_wait   = ft & ~out_valid & avail & rd_edge;

	always_ff @(posedge aclk) begin
		if (!aresetn || ptr_rst) begin
			rptr      <= '0;
			rd_hold   <= '0;
			rd_k      <= '0;
			rd_held   <= 1'b0;
			read_data_bus <= '0;
			out_valid <= 1'b0;
			ft_cnt    <= '0;
			rd_sel    <= 1'b0;
		end else if (replay) begin
			// read pointer only; write pointer untouched
			rd_k   <= '0;
			ft_cnt <= '0;
			if (cfg.replay_zero && wptr != '0) begin
				rptr      <= dcbmf_pkg::PTR_ONE;
				rd_hold   <= mem[0];
				rd_held   <= 1'b1;
				read_data_bus <= dcbmf_pkg::pick_piece(mem[0], 2'h0, cfg.rd_shift,
					cfg.little_endian);
				out_valid <= 1'b1;
			end else begin
				rptr      <= '0;
				rd_held   <= 1'b0;
				out_valid <= 1'b0;
			end
		end else if (readback) begin
			read_data_bus <= rd_sel ? 72'(af_off) : 72'(ae_off);
			rd_sel    <= ~rd_sel;
		end else if (step) begin
			// next narrow piece or next long word
			if (held_more) begin
				rd_k      <= rd_k + 2'h1;
				read_data_bus <= dcbmf_pkg::pick_piece(rd_hold, rd_k + 2'h1, cfg.rd_shift,
					cfg.little_endian);
			end else begin
				rptr      <= rptr + dcbmf_pkg::PTR_ONE;
				rd_hold   <= mem_head;
				rd_k      <= '0;
				rd_held   <= 1'b1;
				read_data_bus <= dcbmf_pkg::pick_piece(mem_head, 2'h0, cfg.rd_shift,
					cfg.little_endian);
			end
			out_valid <= 1'b1;
			ft_cnt    <= '0;
		end else if (drain) begin
			out_valid <= 1'b0;
		end else if (ft_wait) begin
			ft_cnt <= ft_cnt + 2'h1;
		end else if (!ft || out_valid || !avail) begin
			ft_cnt <= '0;
		end
	end

	// bus released when deselected or drive disabled; one sync stage late
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rps            <= 1'b0;
			read_data_oe_n <= 1'b1;
		end else begin
			if (rd_edge) begin
				rps <= ~pin_s.read_port_select_n;
			end
			read_data_oe_n <= ~(~pin_s.output_drive_en_n & rps);
		end
	end

	// ======================================
	// flags
	wire ae_now = ~({1'b0, ae_off} >= fill);
	wire af_now = ~(fill >= (dcbmf_pkg::FILL_FULL - {1'b0, af_off}));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_upd <= 1'b0;
			wr_upd <= 1'b0;
		end else begin
			rd_upd <= rd_edge;
			wr_upd <= wr_edge;
		end
	end

	// combined flag meaning follows timing mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			empty_or_output_ready <= 1'b0;
			full_or_input_ready   <= 1'b1;
			half_full_flag        <= 1'b1;
		end else begin
			empty_or_output_ready <= ft ? ~out_valid : avail;
			full_or_input_ready   <= ft ? full_now : ~full_now;
			half_full_flag        <= ~(fill > dcbmf_pkg::FILL_HALF);
		end
	end

	// almost flags move on the side the timing mode allows
	always_ff @(posedge aclk) begin
		if (!aresetn || ptr_rst) begin
			almost_empty_flag <= 1'b0;
			almost_full_flag  <= 1'b1;
		end else begin
			if (rd_upd && (cfg.flag_sync || !ae_now)) begin
				almost_empty_flag <= ae_now;
			end else if (wr_upd && !cfg.flag_sync && ae_now) begin
				almost_empty_flag <= 1'b1;
			end
			if (wr_upd && (cfg.flag_sync || !af_now)) begin
				almost_full_flag <= af_now;
			end else if (rd_upd && !cfg.flag_sync && af_now) begin
				almost_full_flag <= 1'b1;
			end
		end
	end

	// ======================================
	// register bus
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= dcbmf_pkg::RESP_OKAY;
			aw_got        <= 1'b0;
			w_got         <= 1'b0;
			aw_addr       <= '0;
			w_data        <= '0;
			w_strb        <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr       <= s_axi_awaddr;
				aw_got        <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				w_got        <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_got && w_got && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr == dcbmf_pkg::REG_CTRL) ? dcbmf_pkg::RESP_OKAY
					: dcbmf_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_got        <= 1'b0;
				w_got         <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// self-clearing pointer reset from software
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_prst <= 1'b0;
		end else begin
			sw_prst <= aw_got & w_got & ~s_axi_bvalid & (aw_addr == dcbmf_pkg::REG_CTRL)
				& w_strb[0] & w_data[dcbmf_pkg::CTRL_PRST_BIT];
		end
	end

	always_comb begin
		rd_mux = '0;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			dcbmf_pkg::REG_CTRL:    rd_mux = '0;
			dcbmf_pkg::REG_STATUS:  rd_mux = 32'({empty_or_output_ready, full_or_input_ready,
				half_full_flag, almost_empty_flag, almost_full_flag, cfg});
			dcbmf_pkg::REG_FILL:    rd_mux = 32'(fill);
			dcbmf_pkg::REG_OFFSETS: rd_mux = (32'(af_off) << dcbmf_pkg::OFF_AF_LSB)
				| 32'(ae_off);
			default:                rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= dcbmf_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_mux;
			s_axi_rresp   <= rd_hit ? dcbmf_pkg::RESP_OKAY : dcbmf_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ======================================
	// checks
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence seq_clean_read;
		!ptr_rst && !replay && !readback;
	endsequence
	sequence seq_word_commit;
		wr_commit && !ptr_rst;
	endsequence

	chk_write_store: assert property (seq_word_commit |=> wptr == $past(wptr) + 10'h001)
		else $error("committed word did not advance write pointer");
	chk_read_fetch: assert property (seq_clean_read and (step && !held_more)
		|=> rptr == $past(rptr) + 10'h001)
		else $error("read fetch did not advance read pointer");
	chk_drive_off: assert property (pin_s.output_drive_en_n |=> read_data_oe_n)
		else $error("bus driven while drive enable off");
	chk_select_off: assert property ((rd_edge && pin_s.read_port_select_n)
		|=> ##1 read_data_oe_n)
		else $error("bus driven while port deselected");
	chk_standard_hold: assert property ((!ft && !ren_ok && !replay && !ptr_rst)
		|=> $stable(read_data_bus))
		else $error("standard mode output moved without a read");
	chk_fall_through: assert property ((ft && ft_fire && !ptr_rst && !replay
		&& !readback) |=> out_valid ##1 !empty_or_output_ready)
		else $error("fall-through word not presented");
	chk_mode_latch: assert property (full_rst
		|=> cfg.fall_through_mode == $past(pin_s.mode_or_serial_pin))
		else $error("timing mode not latched at full reset");
	chk_full_flag: assert property ((!ft && full_now && !full_rst)
		|=> !full_or_input_ready)
		else $error("full flag missing in standard mode");
	chk_reset_clear: assert property (ptr_rst
		|=> wptr == '0 && rptr == '0 && read_data_bus == '0)
		else $error("reset left pointers or output set");
	chk_replay_ptr: assert property ((replay && !ptr_rst && !wr_commit)
		|=> $stable(wptr) && rptr <= 10'h001)
		else $error("replay disturbed pointers");
	chk_sync_empty: assert property ((cfg.flag_sync && !rd_upd && !ptr_rst && !full_rst)
		|=> $stable(almost_empty_flag))
		else $error("almost-empty moved off the read side");
endmodule

// File: common/dcbmf_pkg.sv
// Overview of operation
// - each write clock rise with write enable low stores one word from the write bus.
// - each read clock rise with read enable low moves one word toward the read bus.
// - output drive enable gates the read bus drivers; deasserted means released.
// - read port select sampled on read clock; deselected ignores read enable, releases bus.
// - read and write clocks are independent, any rate from standstill up to half the aclk rate, as aclk samples them.
// - standard mode: first word reaches the read bus only after an explicit read.
// - fall-through mode: first word appears after three read clocks; later words need reads.
// - fall-through versus standard mode is latched from the mode pin during full reset.
// - combined flags are empty/full in standard, output/input ready in fall-through mode.
// - full reset picks one of eight default offsets from two choice pins and load strobe.
// - serial load enable with load strobe shifts one offset bit per serial clock rise.
// - write enable with load strobe captures offsets from the write bus on write clock.
// - read enable with load strobe presents the offsets on the read bus.
// - full reset zeroes both pointers and relatches every reset-time mode.
// - pointer reset zeroes pointers, keeps modes and offsets; flags recomputed.
// - both resets clear the output register to zero.
// - asynchronous flag mode: almost flags assert on one side, release on the other.
// - synchronous flag mode: almost-empty moves on read clock, almost-full on write clock.
// - replay request low at a read clock rise sets only the read pointer: to 0, or to 1 when zero latency preloads word 0.
// - replay latency select at full reset: low zero latency, high normal latency.
// - zero-latency replay loads the first word on the same read clock rise.
// - widths follow match enable and width selects: 72/72, or 72 with 36 or 18.
// - big-endian passes the most significant narrow word first, little-endian the least.
// - word order select low at full reset means big-endian, high little-endian.
// - interspersed parity treats D8 as parity; otherwise D8 is data, D16 and D17 ignored.
// - parity layout select at full reset: low non-interspersed, high interspersed.
package dcbmf_pkg;
	localparam int             DATA_W        = 72;
	localparam int             DEPTH         = 512;
	localparam int             PTR_W         = 10;
	localparam int             ADDR_W        = 9;
	localparam int             OFF_W         = 9;
	localparam int             PARITY_BIT    = 8;
	localparam logic [9:0]     FILL_FULL     = 10'h200;
	localparam logic [9:0]     FILL_HALF     = 10'h100;
	localparam logic [9:0]     PTR_ONE       = 10'h001;
	localparam logic [1:0]     FT_LAST       = 2'h2;
	localparam logic [1:0]     SHIFT_X72     = 2'h0;
	localparam logic [1:0]     SHIFT_X36     = 2'h1;
	localparam logic [1:0]     SHIFT_X18     = 2'h2;
	// ======================================
	// register map
	localparam logic [7:0]     REG_CTRL      = 8'h00;
	localparam logic [7:0]     REG_STATUS    = 8'h04;
	localparam logic [7:0]     REG_FILL      = 8'h08;
	localparam logic [7:0]     REG_OFFSETS   = 8'h0C;
	localparam int             CTRL_PRST_BIT = 0;
	localparam int             OFF_AF_LSB    = 16;
	localparam logic [1:0]     RESP_OKAY     = 2'h0;
	localparam logic [1:0]     RESP_SLVERR   = 2'h2;
	// default offsets, indexed by {load strobe, choice 1, choice 0}
	localparam logic [8:0]     DEFAULT_OFF [8] = '{9'h007, 9'h00F, 9'h01F, 9'h03F,
		9'h07F, 9'h0FF, 9'h003, 9'h1FF};

	typedef struct packed {
		logic        write_clk;
		logic        read_clk;
		logic        serial_clk;
		logic        write_en_n;
		logic        read_en_n;
		logic        load_strobe_n;
		logic        serial_load_enable_n;
		logic        mode_or_serial_pin;
		logic        full_reset_n;
		logic        pointer_reset_n;
		logic        replay_request_n;
		logic        replay_latency_select;
		logic        level_flag_timing_select;
		logic        width_match_enable;
		logic        write_width_select;
		logic        read_width_select;
		logic        word_order_select;
		logic        parity_layout_select;
		logic        default_choice_0;
		logic        default_choice_1;
		logic        read_port_select_n;
		logic        output_drive_en_n;
		logic [71:0] write_data_bus;
	} dcbmf_pins_s;

	typedef struct packed {
		logic       fall_through_mode;
		logic       replay_zero;
		logic       flag_sync;
		logic       little_endian;
		logic       interspersed;
		logic [1:0] wr_shift;
		logic [1:0] rd_shift;
	} dcbmf_cfg_s;

	function automatic logic [1:0] last_piece(input logic [1:0] shift);
		return 2'((1 << shift) - 1);
	endfunction

	function automatic logic [71:0] pick_piece(input logic [71:0] w, input logic [1:0] k,
		input logic [1:0] shift, input logic little);
		int wid;
		int p;
		wid = DATA_W >> shift;
		p = little ? int'(k) : int'(last_piece(shift)) - int'(k);
		return (w >> (p * wid)) & ({DATA_W{1'b1}} >> (DATA_W - wid));
	endfunction

	function automatic logic [71:0] place_piece(input logic [71:0] acc, input logic [71:0] d,
		input logic [1:0] k, input logic [1:0] shift, input logic little);
		int wid;
		int p;
		wid = DATA_W >> shift;
		p = little ? int'(k) : int'(last_piece(shift)) - int'(k);
		return acc | ((d & ({DATA_W{1'b1}} >> (DATA_W - wid))) << (p * wid));
	endfunction
endpackage

// File: testbench/dcbmf_peer.sv
`timescale 1ns/1ps
// ==========
// producer and consumer clocks; both stand still between requests
module dcbmf_peer (
	input  wire logic aclk,
	input  wire logic wr_go,
	input  wire logic rd_go,
	output logic      write_clk,
	output logic      read_clk
);
	logic [2:0] wc = 3'h0;
	logic [2:0] rc = 3'h0;
	// one rise per request, phases of three aclk
	always @(posedge aclk) begin
		if (wr_go)
			wc <= 3'h6;
		else if (wc != 3'h0)
			wc <= wc - 3'h1;
		if (rd_go)
			rc <= 3'h6;
		else if (rc != 3'h0)
			rc <= rc - 3'h1;
	end
	assign write_clk = wc > 3'h3;
	assign read_clk  = rc > 3'h3;
endmodule

// File: testbench/dcbmf_test.sv
`timescale 1ns/1ps
module dual_clock_bus_matching_fifo_test;
	logic aclk = 0, aresetn = 0, serial_clk = 0, write_en_n = 1, read_en_n = 1, wr_go = 0;
	logic load_strobe_n = 1, serial_load_enable_n = 1, mode_or_serial_pin = 0, rd_go = 0;
	logic full_reset_n = 1, pointer_reset_n = 1, replay_request_n = 1, replay_latency_select = 0;
	logic level_flag_timing_select = 0, width_match_enable = 0, write_width_select = 0;
	logic read_width_select = 0, word_order_select = 0, parity_layout_select = 0;
	logic default_choice_0 = 0, default_choice_1 = 0, read_port_select_n = 0, output_drive_en_n = 0;
	logic write_clk, read_clk, read_data_oe_n, empty_or_output_ready, full_or_input_ready;
	logic half_full_flag, almost_empty_flag, almost_full_flag, s_axi_awready, s_axi_wready;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [71:0] write_data_bus = 72'h0, read_data_bus;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	localparam logic [71:0] WB = 72'hC3_5A5A_0F0F_A5A5_0000;
	// serial offsets {almost-full, almost-empty}, sent most significant bit first
	localparam logic [17:0] OFS = {9'h0AB, 9'h0CD};
	int err_total = 0, compares = 0, cyc = 0;
	dcbmf_top dcbmf_top_i (.*);
	dcbmf_peer dcbmf_peer_i (.*);
	always #2 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 6000) begin
			err_total++;
			test_done();
		end
	end
	// ==========
	// tasks
	task chk(input logic [71:0] seen, input logic [71:0] exp, input string nm);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task test_done();
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// one port clock pulse; enable and data held through it
	task pulse(input bit w, input logic en_n, input logic [71:0] d);
		@(posedge aclk);
		write_data_bus <= d;
		if (w) write_en_n <= en_n; else read_en_n <= en_n;
		if (w) wr_go <= 1'h1; else rd_go <= 1'h1;
		@(posedge aclk);
		wr_go <= 1'h0;
		rd_go <= 1'h0;
		repeat (8) @(posedge aclk);
		write_en_n <= 1'h1;
		read_en_n <= 1'h1;
	endtask
	task mstr(input logic ft);
		repeat (3) @(posedge aclk);
		mode_or_serial_pin <= ft;
		full_reset_n <= 1'h0;
		repeat (6) @(posedge aclk);
		full_reset_n <= 1'h1;
		repeat (4) @(posedge aclk);
		mode_or_serial_pin <= 1'h0;
	endtask
	task axr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		rr = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	// ==========
	// sequence
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		mstr(1'h0);
		axr(8'h0C); chk(rv, 32'h007F_007F, "offsets");
		chk(empty_or_output_ready, 1'h0, "empty");
		for (int i = 0; i < 3; i++) pulse(1, 1'h0, WB + i);
		axr(8'h08); chk(rv, 32'h3, "fill");
		chk(read_data_bus, 72'h0, "before read");
		pulse(0, 1'h0, 72'h0); chk(read_data_bus, WB, "read 0");
		chk(read_data_oe_n, 1'h0, "driven");
		output_drive_en_n <= 1'h1;
		repeat (4) @(posedge aclk);
		chk(read_data_oe_n, 1'h1, "drive off");
		output_drive_en_n <= 1'h0;
		read_port_select_n <= 1'h1;
		pulse(0, 1'h0, 72'h0); chk(read_data_bus, WB, "deselected");
		chk(read_data_oe_n, 1'h1, "released");
		read_port_select_n <= 1'h0;
		pulse(0, 1'h0, 72'h0); chk(read_data_bus, WB + 1, "read 1");
		replay_request_n <= 1'h0;
		pulse(0, 1'h1, 72'h0); chk(read_data_bus, WB, "replay");
		replay_request_n <= 1'h1;
		load_strobe_n <= 1'h0;
		pulse(0, 1'h0, 72'h0); chk(read_data_bus, 72'h7F, "readback");
		load_strobe_n <= 1'h1;
		axw(8'h00, 32'h1); chk(rr, 2'h0, "ctrl resp");
		repeat (4) @(posedge aclk); chk(read_data_bus, 72'h0, "cleared");
		axr(8'h0C); chk(rv, 32'h007F_007F, "kept");
		load_strobe_n <= 1'h0;
		pulse(1, 1'h0, 72'h123);
		pulse(1, 1'h0, 72'h45);
		axr(8'h0C);
		chk(rv, 32'h0045_0123, "parallel");
		serial_load_enable_n <= 1'h0;
		// one bit per serial clock rise
		for (int i = 17; i >= 0; i--) begin
			repeat (3) @(posedge aclk);
			mode_or_serial_pin <= OFS[i];
			serial_clk <= 1'h1;
			repeat (3) @(posedge aclk);
			serial_clk <= 1'h0;
		end
		load_strobe_n <= 1'h1;
		serial_load_enable_n <= 1'h1;
		mode_or_serial_pin <= 1'h0;
		axr(8'h0C);
		chk(rv, 32'h00AB_00CD, "serial");
		axr(8'h10); chk(rr, 2'h2, "unmapped");
		width_match_enable <= 1'h1;
		write_width_select <= 1'h1;
		mstr(1'h1);
		pulse(1, 1'h0, 72'h5_A5A5_A5A5);
		pulse(1, 1'h0, 72'hF_0F0F_0F0F);
		repeat (2) pulse(0, 1'h1, 72'h0);
		chk(read_data_bus, 72'h0, "ft early");
		pulse(0, 1'h1, 72'h0);
		chk(read_data_bus, 72'h5A_5A5A_5A5F_0F0F_0F0F, "ft shown");
		chk(empty_or_output_ready, 1'h0, "ready");
		test_done();
	end
endmodule
